/* verilog/prl_pkg.sv */
// shared constants and types for the port rate limiter and shaper
`default_nettype none

package prl_pkg;

    // credit update period and its cycle count at 200 MHz
    localparam int TICK_NS  = 1000;
    localparam int CLK_NS   = 5;
    localparam int TICK_CYC = TICK_NS / CLK_NS;

    // structure widths
    localparam int NQ = 4;   // priorities / queues per port
    localparam int LW = 14;  // frame length in bytes
    localparam int RW = 16;  // rate and slope in Mbps (bits per tick)
    localparam int BW = 21;  // charged frame size in bits
    localparam int CW = 24;  // signed credit

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ING  = 8'h10;
    localparam logic [7:0] ADDR_EGR  = 8'h20;
    localparam logic [7:0] ADDR_CBS  = 8'h30;
    localparam logic [7:0] ADDR_STAT = 8'h40;

    // field positions
    localparam int CTRL_SPD  = 0;   // 1 = 100 Mbps link
    localparam int CTRL_IFG  = 1;   // charge inter-frame gap
    localparam int CTRL_PRE  = 2;   // charge preamble
    localparam int CTRL_4Q   = 3;   // 1 = four queues, 0 = two
    localparam int CTRL_TSEL = 4;   // [7:4] all, mcast, bcast, flood
    localparam int CTRL_CBS  = 8;   // [11:8] shaper enable per queue
    localparam int CBS_SEND  = 16;  // send slope in upper half
    localparam int STAT_ELIG = 16;  // [19:16] eligible queues
    localparam int STAT_BUSY = 20;  // transmit in progress

    // reset values
    localparam logic [31:0]   CTRL_RST = 32'h0000_0019;
    localparam logic [RW-1:0] RATE_RST = 16'h0000;
    localparam logic [31:0]   CBS_RST  = 32'h0000_0000;

    // speed limits and added byte counts
    localparam logic [RW-1:0] SPD10_MBPS  = 16'h000a;
    localparam logic [RW-1:0] SPD100_MBPS = 16'h0064;
    localparam logic [17:0]   IFG_BYTES   = 18'h0000c;
    localparam logic [17:0]   PRE_BYTES   = 18'h00008;
    localparam logic signed [CW-1:0] CREDIT_CAP = 24'sh003030;

    // bus answers
    localparam logic [1:0] RESP_OK     = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // transmit scheduler states
    typedef enum logic {TX_IDLE, TX_SEND} prl_tx_state_t;

endpackage : prl_pkg

`default_nettype wire

/* verilog/prl_port_rate_limit_shaper.sv */
// per-port ingress policer, egress leaky bucket and credit-based shaper
// Functional notes
// R1: ingress and egress limiters run independently
// R2: rate above link speed means unlimited
// R3: ingress rate per priority per port
// R4: egress rate per output queue
// R5: charge DA..FCS, optionally IFG and preamble
// R6: only selected frame types are metered
// R7: over-limit selected frames dropped at ingress
// R8: leaky bucket meters each output queue
// R9: stretch gap after frames to smooth output
// R10: excess held queued; full memory raises flow control
// R11: software should set egress above ingress
// R12: shaper per queue, one or two enabled
// R13: shaper eligible: top two of four, or queue 1
// R14: best-effort queues strict priority, shaper off
// R15: shaped queue never exceeds reserved bandwidth
// R16: waiting shaped queue builds credit
// R17: unused shaped bandwidth goes to others
// R18: strict priority, queue 3 highest
// R19: credit rises idle, falls sending, start at >=0
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module prl_port_rate_limit_shaper
    import prl_pkg::*;
(
    input  wire logic            clk_sys,
    input  wire logic            rst_b,
    // register bus
    input  wire logic [7:0]      awaddr,
    input  wire logic [2:0]      awprot,
    input  wire logic            awvalid,
    output logic                 awready,
    input  wire logic [31:0]     wdata,
    input  wire logic [3:0]      wstrb,
    input  wire logic            wvalid,
    output logic                 wready,
    output logic [1:0]           bresp,
    output logic                 bvalid,
    input  wire logic            bready,
    input  wire logic [7:0]      araddr,
    input  wire logic [2:0]      arprot,
    input  wire logic            arvalid,
    output logic                 arready,
    output logic [31:0]          rdata,
    output logic [1:0]           rresp,
    output logic                 rvalid,
    input  wire logic            rready,
    // receive frame descriptors
    input  wire logic            rxValid,
    input  wire logic [LW-1:0]   rxLen,
    input  wire logic [1:0]      rxPrio,
    input  wire logic            rxMcast,
    input  wire logic            rxBcast,
    input  wire logic            rxFlood,
    output logic                 rxPass,
    output logic                 rxDrop,
    // output queues
    input  wire logic [NQ-1:0]   qPending,
    input  wire logic [NQ*LW-1:0] qLen,
    input  wire logic [NQ-1:0]   qMemFull,
    output logic                 flowCtrl,
    // transmit MAC
    output logic                 txGo,
    output logic [1:0]           txQueue,
    output logic [LW-1:0]        txLen,
    input  wire logic            txDone
);

    localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
    localparam logic signed [CW:0] CAP_X = {1'b0, CREDIT_CAP};

    // configuration and state
    logic [31:0]          ctrl;              // control word
    logic [RW-1:0]        ingRate [NQ];      // ingress Mbps per priority
    logic [RW-1:0]        egrRate [NQ];      // egress Mbps per queue
    logic [31:0]          cbsCfg  [NQ];      // idle and send slopes
    logic signed [CW-1:0] ingCredit [NQ];    // ingress buckets
    logic signed [CW-1:0] egrCredit [NQ];    // egress buckets
    logic signed [CW-1:0] cbsCredit [NQ];    // shaper credits
    logic [7:0]           tickCnt;           // microsecond divider
    logic [15:0]          dropCnt;           // dropped frames
    prl_tx_state_t        state;             // scheduler state

    // credit step with upper saturation
    function automatic logic signed [CW-1:0] cstep(input logic signed [CW-1:0] c,
                                                   input logic [RW-1:0] add,
                                                   input logic [BW-1:0] sub);
        logic signed [CW:0] s;
        s = $signed({c[CW-1], c}) + $signed({{(CW+1-RW){1'b0}}, add})
            - $signed({{(CW+1-BW){1'b0}}, sub});
        cstep = (s > CAP_X) ? CREDIT_CAP : s[CW-1:0];
    endfunction : cstep

    // frame size in bits with optional gap and preamble
    function automatic logic [BW-1:0] fbits(input logic [LW-1:0] len, input logic [31:0] cfg);
        logic [17:0] b;
        b = {4'h0, len} + (cfg[CTRL_IFG] ? IFG_BYTES : 18'h0) + (cfg[CTRL_PRE] ? PRE_BYTES : 18'h0);
        fbits = {b, 3'h0};
    endfunction : fbits

    // ---- bus decode
    wire         wrHit  = awvalid && wvalid && !bvalid;
    wire [31:0]  wMask  = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
    wire [31:0]  wCtrl  = (ctrl & ~wMask) | (wdata & wMask);
    wire         wrCtrl = awaddr[7:2] == ADDR_CTRL[7:2];
    wire         wrIng  = awaddr[7:4] == ADDR_ING[7:4];
    wire         wrEgr  = awaddr[7:4] == ADDR_EGR[7:4];
    wire         wrCbs  = awaddr[7:4] == ADDR_CBS[7:4];
    wire         wrMap  = wrCtrl || wrIng || wrEgr || wrCbs;
    wire [1:0]   wIdx   = awaddr[3:2];
    wire [1:0]   rIdx   = araddr[3:2];
    assign awready = wrHit;
    assign wready  = wrHit;
    assign arready = !rvalid;

    // ---- common decode
    wire         tick     = tickCnt == TICK_LAST;
    wire [RW-1:0] spdMax  = ctrl[CTRL_SPD] ? SPD100_MBPS : SPD10_MBPS;
    wire [3:0]   tsel     = ctrl[CTRL_TSEL +: 4];
    wire [NQ-1:0] cbsAllow = ctrl[CTRL_4Q] ? 4'hc : 4'h2;               // R13
    wire [NQ-1:0] cbsOn    = ctrl[CTRL_CBS +: NQ] & cbsAllow;            // R12 R14
    logic [NQ-1:0] ingUnlim;
    logic [NQ-1:0] egrUnlim;
    logic [NQ-1:0] elig;

    // unlimited and eligibility per queue
    always_comb begin
        for (int i = 0; i < NQ; i++) begin
            ingUnlim[i] = ingRate[i] == '0 || ingRate[i] > spdMax;       // R2
            egrUnlim[i] = egrRate[i] == '0 || egrRate[i] > spdMax;       // R2
            elig[i] = qPending[i] && (egrUnlim[i] || !egrCredit[i][CW-1]) // R8 R9
                      && (!cbsOn[i] || !cbsCredit[i][CW-1]);             // R15 R19
        end
    end

    // ---- ingress decision
    wire         rxSel     = tsel[0] || (tsel[1] && rxMcast)              // R6
                             || (tsel[2] && rxBcast) || (tsel[3] && rxFlood);
    wire         rxLim     = rxSel && !ingUnlim[rxPrio];
    wire         rxNeg     = ingCredit[rxPrio][CW-1];
    wire         ingTake   = rxValid && rxLim && !rxNeg;
    wire         rxDropNow = rxValid && rxLim && rxNeg;                   // R7
    wire [BW-1:0] rxBits   = fbits(rxLen, ctrl);                          // R5

    // ---- egress selection, highest pending eligible queue first
    wire         anyElig  = |elig;                                        // R17
    wire [1:0]   selQ     = elig[3] ? 2'h3 : elig[2] ? 2'h2 : elig[1] ? 2'h1 : 2'h0; // R18 R14
    wire [LW-1:0] qLenSel = qLen[selQ*LW +: LW];
    wire [BW-1:0] selBits = fbits(qLenSel, ctrl);                         // R5
    wire         startNow = state == TX_IDLE && anyElig;

    // microsecond credit tick
    always_ff @(posedge clk_sys) begin
        if (!rst_b || tick) begin
            tickCnt <= 8'h00;
        end else begin
            tickCnt <= tickCnt + 8'h01;
        end
    end

    // register writes and write response
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ctrl   <= CTRL_RST;
            bvalid <= 1'b0;
            bresp  <= RESP_OK;
            ingRate <= '{default: RATE_RST};
            egrRate <= '{default: RATE_RST};
            cbsCfg  <= '{default: CBS_RST};
        end else begin
            if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
            if (wrHit) begin
                bvalid <= 1'b1;
                bresp  <= wrMap ? RESP_OK : RESP_DECERR;
                if (wrCtrl) begin
                    ctrl <= wCtrl;
                end
                for (int i = 0; i < NQ; i++) begin
                    if (wIdx == 2'(i)) begin
                        if (wrIng) begin
                            ingRate[i] <= (ingRate[i] & ~wMask[RW-1:0]) | (wdata[RW-1:0] & wMask[RW-1:0]);
                        end
                        if (wrEgr) begin
                            egrRate[i] <= (egrRate[i] & ~wMask[RW-1:0]) | (wdata[RW-1:0] & wMask[RW-1:0]);
                        end
                        if (wrCbs) begin
                            cbsCfg[i] <= (cbsCfg[i] & ~wMask) | (wdata & wMask);
                        end
                    end
                end
            end
        end
    end

    // read data mux
    logic [31:0] rdNext;
    logic [1:0]  rrNext;
    always_comb begin
        rdNext = 32'h0000_0000;
        rrNext = RESP_OK;
        if (araddr[7:2] == ADDR_CTRL[7:2]) begin
            rdNext = ctrl;
        end else if (araddr[7:4] == ADDR_ING[7:4]) begin
            rdNext = {16'h0000, ingRate[rIdx]};
        end else if (araddr[7:4] == ADDR_EGR[7:4]) begin
            rdNext = {16'h0000, egrRate[rIdx]};
        end else if (araddr[7:4] == ADDR_CBS[7:4]) begin
            rdNext = cbsCfg[rIdx];
        end else if (araddr[7:2] == ADDR_STAT[7:2]) begin
            rdNext = {11'h000, state == TX_SEND, elig, dropCnt};
        end else begin
            rrNext = RESP_DECERR;
        end
    end

    // read response
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= RESP_OK;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rdNext;
            rresp  <= rrNext;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ingress buckets per priority, refilled every tick
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rxPass  <= 1'b0;
            rxDrop  <= 1'b0;
            dropCnt <= 16'h0000;
            ingCredit <= '{default: '0};
        end else begin
            rxPass <= rxValid && !rxDropNow;                              // R1
            rxDrop <= rxDropNow;                                          // R7
            if (rxDropNow) begin
                dropCnt <= dropCnt + 16'h0001;
            end
            for (int i = 0; i < NQ; i++) begin
                if (ingUnlim[i]) begin
                    ingCredit[i] <= '0;
                end else begin
                    ingCredit[i] <= cstep(ingCredit[i], tick ? ingRate[i] : '0,      // R3
                                          (ingTake && rxPrio == 2'(i)) ? rxBits : '0);
                end
            end
        end
    end

    // egress leaky buckets, charged at frame start
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            egrCredit <= '{default: '0};
        end else begin
            for (int i = 0; i < NQ; i++) begin
                if (egrUnlim[i]) begin
                    egrCredit[i] <= '0;                                   // R1
                end else begin
                    egrCredit[i] <= cstep(egrCredit[i], tick ? egrRate[i] : '0,      // R4 R8
                                          (startNow && selQ == 2'(i)) ? selBits : '0);
                end
            end
        end
    end

    // credit-based shaper per queue
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cbsCredit <= '{default: '0};
        end else begin
            for (int i = 0; i < NQ; i++) begin
                if (!cbsOn[i]) begin
                    cbsCredit[i] <= '0;                                   // R14
                end else if (state == TX_SEND && txQueue == 2'(i)) begin
                    // sending drains at the send slope
                    cbsCredit[i] <= cstep(cbsCredit[i], '0,                          // R19
                                          tick ? {{(BW-RW){1'b0}}, cbsCfg[i][CBS_SEND +: RW]} : '0);
                end else if (qPending[i] || cbsCredit[i][CW-1]) begin
                    // waiting or recovering gains at the idle slope
                    cbsCredit[i] <= cstep(cbsCredit[i], tick ? cbsCfg[i][RW-1:0] : '0, '0); // R16 R19
                end else if (cbsCredit[i] > 0) begin
                    cbsCredit[i] <= '0;                                   // R17
                end
            end
        end
    end

    // transmit scheduler and flow control
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state    <= TX_IDLE;
            txGo     <= 1'b0;
            txQueue  <= 2'h0;
            txLen    <= '0;
            flowCtrl <= 1'b0;
        end else begin
            txGo     <= 1'b0;
            flowCtrl <= |qMemFull;                                        // R10
            case (state)
                TX_IDLE: begin
                    if (anyElig) begin
                        state   <= TX_SEND;                               // R18
                        txGo    <= 1'b1;
                        txQueue <= selQ;
                        txLen   <= qLenSel;
                    end
                end
                TX_SEND: begin
                    if (txDone) begin
                        state <= TX_IDLE;                                 // R9
                    end
                end
                default: begin
                    state <= TX_IDLE;
                end
            endcase
        end
    end

    // ---- checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence sq_start;
        state == TX_IDLE && anyElig;
    endsequence
    sequence sq_launch;
        txGo && state == TX_SEND;
    endsequence
    chk_tx_launch: assert property (sq_start |=> sq_launch) // R18
        else $error("eligible queue not launched");
    chk_tx_order: assert property (startNow |=> txQueue == $past(selQ)) // R18
        else $error("launched queue is not the highest eligible");
    chk_tx_hold: assert property (state == TX_SEND && !txDone |=> state == TX_SEND && !txGo) // R9
        else $error("second frame started before done");
    chk_ing_unsel: assert property (rxValid && !rxSel |=> rxPass && !rxDrop) // R6
        else $error("unselected frame type was policed");
    chk_ing_unlim: assert property (rxValid && ingUnlim[rxPrio] |=> rxPass) // R2
        else $error("unlimited rate dropped a frame");
    chk_ing_drop: assert property (rxValid && rxLim && ingCredit[rxPrio] < 0 |=> rxDrop && !rxPass) // R7
        else $error("over-limit frame not dropped");
    chk_cbs_count: assert property ($countones(cbsOn) <= 2 && (cbsOn & 4'h1) == 4'h0) // R12 R13
        else $error("shaper on an ineligible queue");
    chk_cbs_gate: assert property (startNow && cbsOn[selQ] |-> cbsCredit[selQ] >= 0) // R15
        else $error("shaped queue started with negative credit");
    chk_flow_ctrl: assert property (|qMemFull |=> flowCtrl) // R10
        else $error("full queue memory did not raise flow control");
    chk_tick_gap: assert property (tick |=> (!tick)[*8])
        else $error("credit tick too frequent");
    chk_axi_bresp: assert property (wrHit |=> bvalid)
        else $error("write response missing");
    chk_axi_bhold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response not held");
    chk_axi_rresp: assert property (arvalid && arready |=> rvalid)
        else $error("read response missing");

endmodule : prl_port_rate_limit_shaper

`default_nettype wire

/* tb/prl_qmac_model.sv */
// queue manager and transmit mac model facing the limiter
`timescale 1ns/1ps
`default_nettype none

module prl_qmac_model
    import prl_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire logic [NQ-1:0]    load,     // one frame in per queue
    input  wire logic [LW-1:0]    frameLen, // head length, all queues
    input  wire logic             slow,     // long wire time
    input  wire logic             txGo,
    input  wire logic [1:0]       txQueue,
    output logic      [NQ-1:0]    qPending,
    output logic      [NQ*LW-1:0] qLen,
    output logic      [NQ-1:0]    qMemFull,
    output logic                  txDone
);
    logic [NQ-1:0][3:0] cnt;  // frames held per queue
    logic [7:0]         left; // cycles until frame done

    // queue fill and drain
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cnt <= '0;
        end else begin
            for (int i = 0; i < NQ; i++) begin
                cnt[i] <= cnt[i] + 4'(load[i]) - 4'(txGo && txQueue == 2'(i));
            end
        end
    end

    // wire time, never done in the launch cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            left   <= 8'h00;
            txDone <= 1'b0;
        end else begin
            txDone <= (left == 8'h01);
            if (txGo) begin
                left <= slow ? 8'h28 : 8'h03;
            end else if (left != 8'h00) begin
                left <= left - 8'h01;
            end
        end
    end

    // empty queue shows no stale length
    always_comb begin
        for (int i = 0; i < NQ; i++) begin
            qPending[i]       = (cnt[i] != 4'h0);
            qMemFull[i]       = (cnt[i] >= 4'h3);
            qLen[i*LW +: LW]  = qPending[i] ? frameLen : ~frameLen;
        end
    end
endmodule : prl_qmac_model

`default_nettype wire

/* tb/test_port_rate_limit_shaper.sv */
// self-checking bench for the port rate limiter and shaper
`timescale 1ns/1ps
`default_nettype none

module test_port_rate_limit_shaper
    import prl_pkg::*;
;
    logic             clk_sys, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
    logic             arvalid, arready, rvalid, rready, rxValid, rxMcast, rxBcast, rxFlood;
    logic             rxPass, rxDrop, flowCtrl, txGo, txDone, slow;
    logic [7:0]       awaddr, araddr;
    logic [31:0]      wdata, rdata, seed;
    logic [1:0]       bresp, rresp, rxPrio, txQueue;
    logic [LW-1:0]    rxLen, txLen, frameLen;
    logic [NQ-1:0]    qPending, qMemFull, load;
    logic [NQ*LW-1:0] qLen;
    logic [1:0]       wrQ[$];  // expected write answers
    logic [65:0]      rdQ[$];  // resp, data, mask
    logic             rxQ[$];  // 1 = pass expected
    logic [15:0]      txQ[$];  // queue, length
    int               n_errors, total_checks, cyc, t1, t2, tk;

    prl_port_rate_limit_shaper i_prl_port_rate_limit_shaper (
        .clk_sys(clk_sys), .rst_b(rst_b), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .rxValid(rxValid), .rxLen(rxLen), .rxPrio(rxPrio), .rxMcast(rxMcast),
        .rxBcast(rxBcast), .rxFlood(rxFlood), .rxPass(rxPass), .rxDrop(rxDrop),
        .qPending(qPending), .qLen(qLen), .qMemFull(qMemFull), .flowCtrl(flowCtrl),
        .txGo(txGo), .txQueue(txQueue), .txLen(txLen), .txDone(txDone));

    prl_qmac_model i_prl_qmac_model (
        .clk_sys(clk_sys), .rst_b(rst_b), .load(load), .frameLen(frameLen), .slow(slow),
        .txGo(txGo), .txQueue(txQueue), .qPending(qPending), .qLen(qLen),
        .qMemFull(qMemFull), .txDone(txDone));

    // 200 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // compare and count
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // gap lies within bounds
    task automatic chkRange(input int v, input int lo, input int hi);
        total_checks++;
        if (v < lo || v > hi) begin
            n_errors++;
            $display("mismatch at %0t: gap %0d not in %0d..%0d", $time, v, lo, hi);
        end
    endtask : chkRange

    // bus write with expected answer noted
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        wrQ.push_back(er);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do @(posedge clk_sys); while (!awready);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        bready  <= 1'b1;
        do @(posedge clk_sys); while (!bvalid);
        bready <= 1'b0;
    endtask : axw

    // bus read with expected data and mask noted
    task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                       input logic [1:0] er);
        rdQ.push_back({er, d, m});
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge clk_sys); while (!arready);
        arvalid <= 1'b0;
        rready  <= 1'b1;
        do @(posedge clk_sys); while (!rvalid);
        rready <= 1'b0;
    endtask : axr

    // one descriptor, valid left high for back to back
    task automatic rx(input logic [1:0] p, input logic [2:0] t, input logic [LW-1:0] n,
                      input logic ps);
        rxQ.push_back(ps);
        rxValid <= 1'b1;
        rxPrio  <= p;
        rxLen   <= n;
        {rxMcast, rxBcast, rxFlood} <= t;
        @(posedge clk_sys);
    endtask : rx

    // watch outputs, take oldest note
    always @(posedge clk_sys) begin : monitor
        logic [65:0] r;
        cyc <= cyc + 1;
        if (bvalid && bready) chk(34'(bresp), 34'(wrQ.pop_front()));
        if (rvalid && rready) begin
            r = rdQ.pop_front();
            chk({rresp, rdata & r[31:0]}, {r[65:64], r[63:32] & r[31:0]});
        end
        if (rxPass || rxDrop) chk(34'({rxPass, rxDrop}), rxQ.pop_front() ? 34'h2 : 34'h1);
        if (txGo) begin
            chk(34'({txQueue, txLen}), 34'(txQ.pop_front()));
            t1 = t2;
            t2 = cyc;
        end
    end

    // verdict
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    // hang guard, run is about 14k cycles
    initial begin : watchdog
        #400000;
        n_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        conclude();
    end

    initial begin : main
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        {rxValid, rxPrio, rxMcast, rxBcast, rxFlood, load, slow} = '0;
        rxLen    = 14'h0040;
        frameLen = 14'h0040;
        seed     = 32'h13acd1b9;
        {n_errors, total_checks, cyc, t1, t2} = '0;
        rst_b = 1'b0;
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        // reset values, unmapped place, rate width
        axr(ADDR_CTRL, CTRL_RST, '1, RESP_OK);
        axr(ADDR_ING + 8'h04, 32'h0, '1, RESP_OK);
        axr(ADDR_EGR + 8'h08, 32'h0, '1, RESP_OK);
        axr(ADDR_CBS + 8'h0c, CBS_RST, '1, RESP_OK);
        axr(8'h50, 32'h0, '1, RESP_DECERR);
        axw(8'h50, 32'hffffffff, RESP_DECERR);
        axw(ADDR_ING, 32'hffff1234, RESP_OK);
        axr(ADDR_ING, 32'h00001234, '1, RESP_OK);
        $display("test registers done");
        // ingress policing per priority and type
        axw(ADDR_ING + 8'h04, 32'h1, RESP_OK);
        rx(2'h1, 3'b000, 14'h0040, 1'b1);
        rx(2'h1, 3'b000, 14'h0040, 1'b0);
        rx(2'h3, 3'b000, 14'h0040, 1'b1);
        rxValid <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            axw(ADDR_CTRL, CTRL_RST & ~32'hf0 | (32'h20 << k), RESP_OK);
            rx(2'h1, 3'b000, 14'h0040, 1'b1);
            rx(2'h1, 3'b100 >> k, 14'h0040, 1'b0);
            rxValid <= 1'b0;
        end
        // rates above link speed do not limit
        for (int s = 0; s < 2; s++) begin
            axw(ADDR_CTRL, CTRL_RST & ~32'(s), RESP_OK);
            axw(ADDR_ING + 8'h04, s ? 32'h0b : 32'h65, RESP_OK);
            for (int k = 0; k < 6; k++) begin
                seed = lfsr(seed);
                rx(2'h1, seed[2:0], 14'h0040 + 14'(seed[12:3]), 1'b1);
            end
            rxValid <= 1'b0;
        end
        axr(ADDR_STAT, 32'h4, 32'hffff, RESP_OK);
        $display("test ingress done");
        // shaper eligibility, four then two queues
        axw(ADDR_CTRL, CTRL_RST | 32'hf00, RESP_OK);
        axr(ADDR_STAT, 32'h00000000, 32'h000f0000, RESP_OK);
        axw(ADDR_CTRL, CTRL_RST & ~32'h8 | 32'hf00, RESP_OK);
        axr(ADDR_STAT, 32'h00000000, 32'h000f0000, RESP_OK);
        axw(ADDR_CTRL, CTRL_RST, RESP_OK);
        $display("test eligibility done");
        // strict priority with a full queue, slow mac
        slow <= 1'b1;
        txQ.push_back({2'h3, 14'h0040});
        repeat (4) txQ.push_back({2'h1, 14'h0040});
        txQ.push_back({2'h0, 14'h0040});
        load <= 4'b1011;
        @(posedge clk_sys);
        load <= 4'b0010;
        repeat (3) @(posedge clk_sys);
        load <= 4'b0000;
        repeat (2) @(posedge clk_sys);
        chk(34'(flowCtrl), 34'h1);
        while (txQ.size() != 0) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
        chk(34'(flowCtrl), 34'h0);
        $display("test priority done");
        // egress leaky bucket stretches the gap
        slow <= 1'b0;
        axw(ADDR_CTRL, CTRL_RST | 32'h6, RESP_OK);
        axw(ADDR_EGR + 8'h08, 32'h0a, RESP_OK);
        repeat (2) txQ.push_back({2'h2, 14'h0040});
        load <= 4'b0100;
        repeat (2) @(posedge clk_sys);
        load <= 4'b0000;
        while (txQ.size() != 0) @(posedge clk_sys);
        tk = ((64 + int'(IFG_BYTES) + int'(PRE_BYTES)) * 8 + 9) / 10;
        chkRange(t2 - t1, (tk - 2) * TICK_CYC, tk * TICK_CYC + 4);
        $display("test egress done");
        conclude();
    end
endmodule : test_port_rate_limit_shaper

`default_nettype wire
